// >>> verilog/msd_pkg.sv
// constants and types shared by the memory space decoder
package msd_pkg;

   // program memory split with the fetch-select pin latched high
   localparam logic [15:0] INT_ROM_LAST = 16'h3FFF;
   // internal data space boundary between lower and upper halves
   localparam logic [7:0]  LOWER_LAST   = 8'h7F;
   // highest external-move address served by the auxiliary ram
   localparam logic [15:0] AUX_LAST     = 16'h00FF;

   // external strobe timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int STROBE_NS     = 300;
   localparam int STROBE_CYC    =
      (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // bit positions in the space select vector
   localparam int SEL_LOWER = 0;
   localparam int SEL_UPPER = 1;
   localparam int SEL_SREG  = 2;
   localparam int SEL_AUX   = 3;
   localparam int SEL_EXT   = 4;
   localparam int SEL_W     = 5;

   typedef enum logic [2:0] {
      MSD_KIND_DIRECT   = 3'h0,
      MSD_KIND_INDIRECT = 3'h1,
      MSD_KIND_STACK    = 3'h2,
      MSD_KIND_XMOV_IDX = 3'h3,
      MSD_KIND_XMOV_PTR = 3'h4
   } msd_kind_e;

   typedef enum logic [2:0] {
      MSD_TGT_NONE  = 3'h0,
      MSD_TGT_LOWER = 3'h1,
      MSD_TGT_UPPER = 3'h2,
      MSD_TGT_SREG  = 3'h3,
      MSD_TGT_AUX   = 3'h4,
      MSD_TGT_EXT   = 3'h5
   } msd_space_e;

   // gray sequence idle, address, strobe, done
   typedef enum logic [1:0] {
      MSD_ST_IDLE   = 2'h0,
      MSD_ST_ADDR   = 2'h1,
      MSD_ST_STROBE = 2'h3,
      MSD_ST_DONE   = 2'h2
   } msd_state_e;

endpackage : msd_pkg

// >>> verilog/msd_space_decode.sv
// combinational choice of target space for fetches and data accesses
`timescale 1ns/100ps
module msd_space_decode (
   input  wire logic               ext_fetch_latched,
   input  wire logic [15:0]        fetch_addr,
   input  wire msd_pkg::msd_kind_e data_kind,
   input  wire logic [15:0]        data_addr,
   input  wire logic               aux_ram_bypass,
   output logic                    fetch_external,
   output msd_pkg::msd_space_e     space
);

   function automatic logic upper_half(input logic [7:0] a);
      upper_half = (a > msd_pkg::LOWER_LAST);
   endfunction : upper_half

   assign fetch_external = !ext_fetch_latched
                           || (fetch_addr > msd_pkg::INT_ROM_LAST);

   always_comb begin
      space = msd_pkg::MSD_TGT_NONE;
      case (data_kind)
         msd_pkg::MSD_KIND_DIRECT: begin
            space = upper_half(data_addr[7:0]) ? msd_pkg::MSD_TGT_SREG
                                               : msd_pkg::MSD_TGT_LOWER;
         end
         // indirect and stack stay in main ram
         msd_pkg::MSD_KIND_INDIRECT,
         msd_pkg::MSD_KIND_STACK: begin
            space = upper_half(data_addr[7:0]) ? msd_pkg::MSD_TGT_UPPER
                                               : msd_pkg::MSD_TGT_LOWER;
         end
         msd_pkg::MSD_KIND_XMOV_IDX: begin
            space = aux_ram_bypass ? msd_pkg::MSD_TGT_EXT
                                   : msd_pkg::MSD_TGT_AUX;
         end
         msd_pkg::MSD_KIND_XMOV_PTR: begin
            space = (!aux_ram_bypass && data_addr <= msd_pkg::AUX_LAST)
                    ? msd_pkg::MSD_TGT_AUX : msd_pkg::MSD_TGT_EXT;
         end
         default: begin
            space = msd_pkg::MSD_TGT_NONE;
         end
      endcase
   end

endmodule : msd_space_decode

// >>> verilog/msd_decoder.sv
// memory space decoder with external data bus sequencer
`timescale 1ns/100ps
module msd_decoder #(
   parameter int STROBE_CYCLES = msd_pkg::STROBE_CYC
) (
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   input  wire logic                     ext_fetch_select_pin,
   input  wire logic                     fetch_req,
   input  wire logic [15:0]              fetch_addr,
   input  wire logic                     data_req,
   input  wire msd_pkg::msd_kind_e       data_kind,
   input  wire logic [15:0]              data_addr,
   input  wire logic                     data_write,
   input  wire logic [7:0]               data_wdata,
   input  wire logic                     aux_ram_bypass,
   input  wire logic [7:0]               port2_out_reg,
   input  wire logic [7:0]               addr_data_port_in,
   output logic                          fetch_int_sel,
   output logic                          fetch_ext_sel,
   output logic [msd_pkg::SEL_W-1:0]     space_sel,
   output logic [7:0]                    target_addr,
   output logic                          ext_busy,
   output logic                          ext_done,
   output logic [7:0]                    ext_rdata,
   output logic [7:0]                    addr_data_port_out,
   output logic                          addr_data_port_oe,
   output logic [7:0]                    high_addr_port,
   output logic                          addr_latch,
   output logic                          wr_strobe_n,
   output logic                          rd_strobe_n
);

   localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYCLES - 1);

   logic                          strap_latched;
   logic                          dec_fetch_ext;
   msd_pkg::msd_space_e           dec_space;
   logic                          accept;
   logic [msd_pkg::SEL_W-1:0]     dec_sel;

   msd_pkg::msd_state_e           state, next_state;
   logic [7:0]                    cnt, next_cnt;
   logic                          cyc_write, next_cyc_write;
   logic                          cyc_ptr, next_cyc_ptr;
   logic [15:0]                   cyc_addr, next_cyc_addr;
   logic [7:0]                    cyc_wdata, next_cyc_wdata;
   logic                          next_fetch_int_sel, next_fetch_ext_sel;
   logic [msd_pkg::SEL_W-1:0]     next_space_sel;
   logic [7:0]                    next_target_addr;
   logic                          next_ext_busy, next_ext_done;
   logic [7:0]                    next_ext_rdata;
   logic [7:0]                    next_ad_out;
   logic                          next_ad_oe;
   logic [7:0]                    next_high_addr_port;
   logic                          next_addr_latch;
   logic                          next_wr_n, next_rd_n;

   // sampled at every rising clock edge while reset is low
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         strap_latched <= ext_fetch_select_pin;
      end
   end

   msd_space_decode u_dec (
      .ext_fetch_latched (strap_latched),
      .fetch_addr        (fetch_addr),
      .data_kind         (data_kind),
      .data_addr         (data_addr),
      .aux_ram_bypass    (aux_ram_bypass),
      .fetch_external    (dec_fetch_ext),
      .space             (dec_space)
   );

   // requests while the bus is busy are dropped
   assign accept = data_req && (state == msd_pkg::MSD_ST_IDLE);

   always_comb begin
      dec_sel = '0;
      case (dec_space)
         msd_pkg::MSD_TGT_LOWER: dec_sel[msd_pkg::SEL_LOWER] = 1'b1;
         msd_pkg::MSD_TGT_UPPER: dec_sel[msd_pkg::SEL_UPPER] = 1'b1;
         msd_pkg::MSD_TGT_SREG:  dec_sel[msd_pkg::SEL_SREG]  = 1'b1;
         msd_pkg::MSD_TGT_AUX:   dec_sel[msd_pkg::SEL_AUX]   = 1'b1;
         msd_pkg::MSD_TGT_EXT:   dec_sel[msd_pkg::SEL_EXT]   = 1'b1;
         default:               dec_sel = '0;
      endcase
   end

   always_comb begin
      next_state          = state;
      next_cnt            = cnt;
      next_cyc_write      = cyc_write;
      next_cyc_ptr        = cyc_ptr;
      next_cyc_addr       = cyc_addr;
      next_cyc_wdata      = cyc_wdata;
      next_ext_rdata      = ext_rdata;
      next_ad_out         = addr_data_port_out;
      next_ad_oe          = addr_data_port_oe;
      next_addr_latch     = 1'b0;
      next_wr_n           = wr_strobe_n;
      next_rd_n           = rd_strobe_n;
      next_ext_done       = 1'b0;
      next_fetch_int_sel  = fetch_req && !dec_fetch_ext;
      next_fetch_ext_sel  = fetch_req && dec_fetch_ext;
      // select registered from the request cycle
      next_space_sel      = accept ? dec_sel : '0;
      next_target_addr    = accept ? data_addr[7:0] : target_addr;
      // port-2 register unless a pointer cycle runs
      next_high_addr_port = port2_out_reg;
      case (state)
         msd_pkg::MSD_ST_IDLE: begin
            // aux and internal accesses leave pins idle
            if (accept && dec_space == msd_pkg::MSD_TGT_EXT) begin
               next_state     = msd_pkg::MSD_ST_ADDR;
               next_cyc_write = data_write;
               next_cyc_ptr   = (data_kind == msd_pkg::MSD_KIND_XMOV_PTR);
               next_cyc_addr  = data_addr;
               next_cyc_wdata = data_wdata;
               // low address to the muxed port
               next_ad_out     = data_addr[7:0];
               next_ad_oe      = 1'b1;
               next_addr_latch = 1'b1;
            end
         end
         msd_pkg::MSD_ST_ADDR: begin
            next_state = msd_pkg::MSD_ST_STROBE;
            next_cnt   = STROBE_LAST;
            next_ad_out = cyc_write ? cyc_wdata : 8'h00;
            next_ad_oe  = cyc_write;
            next_wr_n  = !cyc_write;
            next_rd_n  = cyc_write;
         end
         msd_pkg::MSD_ST_STROBE: begin
            if (cnt == 8'h00) begin
               next_state = msd_pkg::MSD_ST_DONE;
               next_wr_n  = 1'b1;
               next_rd_n  = 1'b1;
               next_ext_done = 1'b1;
               if (!cyc_write) begin
                  next_ext_rdata = addr_data_port_in;
               end
            end else begin
               next_cnt = cnt - 8'h01;
            end
         end
         msd_pkg::MSD_ST_DONE: begin
            next_state = msd_pkg::MSD_ST_IDLE;
            next_ad_oe = 1'b0;
         end
         default: begin
            next_state = msd_pkg::MSD_ST_IDLE;
         end
      endcase
      // pointer high byte during a pointer cycle
      if (next_state != msd_pkg::MSD_ST_IDLE && next_cyc_ptr) begin
         next_high_addr_port = next_cyc_addr[15:8];
      end
      next_ext_busy = (next_state != msd_pkg::MSD_ST_IDLE);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state              <= msd_pkg::MSD_ST_IDLE;
         cnt                <= 8'h00;
         cyc_write          <= 1'b0;
         cyc_ptr            <= 1'b0;
         cyc_addr           <= 16'h0000;
         cyc_wdata          <= 8'h00;
         fetch_int_sel      <= 1'b0;
         fetch_ext_sel      <= 1'b0;
         space_sel          <= '0;
         target_addr        <= 8'h00;
         ext_busy           <= 1'b0;
         ext_done           <= 1'b0;
         ext_rdata          <= 8'h00;
         addr_data_port_out <= 8'h00;
         addr_data_port_oe  <= 1'b0;
         high_addr_port     <= 8'hFF;
         addr_latch         <= 1'b0;
         wr_strobe_n        <= 1'b1;
         rd_strobe_n        <= 1'b1;
      end else begin
         state              <= next_state;
         cnt                <= next_cnt;
         cyc_write          <= next_cyc_write;
         cyc_ptr            <= next_cyc_ptr;
         cyc_addr           <= next_cyc_addr;
         cyc_wdata          <= next_cyc_wdata;
         fetch_int_sel      <= next_fetch_int_sel;
         fetch_ext_sel      <= next_fetch_ext_sel;
         space_sel          <= next_space_sel;
         target_addr        <= next_target_addr;
         ext_busy           <= next_ext_busy;
         ext_done           <= next_ext_done;
         ext_rdata          <= next_ext_rdata;
         addr_data_port_out <= next_ad_out;
         addr_data_port_oe  <= next_ad_oe;
         high_addr_port     <= next_high_addr_port;
         addr_latch         <= next_addr_latch;
         wr_strobe_n        <= next_wr_n;
         rd_strobe_n        <= next_rd_n;
      end
   end

   a_fetch_int_rom: assert property (@(posedge clk) disable iff (!reset_n)
      fetch_req && strap_latched && fetch_addr <= msd_pkg::INT_ROM_LAST
      |=> fetch_int_sel)
      else $error("low fetch with pin high not internal");
   a_fetch_all_ext: assert property (@(posedge clk) disable iff (!reset_n)
      fetch_req && !strap_latched |=> fetch_ext_sel && !fetch_int_sel)
      else $error("fetch with pin low not external");
   a_pin_held_after: assert property (@(posedge clk) disable iff (!reset_n)
      $past(reset_n) |-> $stable(strap_latched))
      else $error("latched pin changed after reset");
   a_direct_low_ram: assert property (@(posedge clk) disable iff (!reset_n)
      accept && data_kind == msd_pkg::MSD_KIND_DIRECT && data_addr[7:0] < 8'h80
      |=> space_sel == 5'h01)
      else $error("direct low address not lower ram");
   a_indirect_upper: assert property (@(posedge clk) disable iff (!reset_n)
      accept && data_kind == msd_pkg::MSD_KIND_INDIRECT && data_addr[7]
      |=> space_sel == 5'h02)
      else $error("indirect high address not upper ram");
   a_direct_sreg: assert property (@(posedge clk) disable iff (!reset_n)
      accept && data_kind == msd_pkg::MSD_KIND_DIRECT && data_addr[7]
      |=> space_sel == 5'h04)
      else $error("direct high address not special space");
   a_aux_pins_quiet: assert property (@(posedge clk) disable iff (!reset_n)
      accept && !aux_ram_bypass && data_kind == msd_pkg::MSD_KIND_XMOV_IDX
      |=> space_sel == 5'h08 && !addr_data_port_oe && wr_strobe_n
          && rd_strobe_n && !ext_busy)
      else $error("aux access touched the bus");
   a_stack_internal: assert property (@(posedge clk) disable iff (!reset_n)
      accept && data_kind == msd_pkg::MSD_KIND_STACK
      |=> !space_sel[msd_pkg::SEL_AUX] && !space_sel[msd_pkg::SEL_EXT])
      else $error("stack reached auxiliary or external space");
   a_strobe_width: assert property (@(posedge clk) disable iff (!reset_n)
      accept && dec_space == msd_pkg::MSD_TGT_EXT && data_write
      |=> addr_latch ##1 (!wr_strobe_n && rd_strobe_n)[*3]
          ##1 (wr_strobe_n && ext_done))
      else $error("write strobe shape wrong");
   a_ptr_high_byte: assert property (@(posedge clk) disable iff (!reset_n)
      accept && aux_ram_bypass && data_kind == msd_pkg::MSD_KIND_XMOV_PTR
      |=> high_addr_port == $past(data_addr[15:8])
          && addr_data_port_out == $past(data_addr[7:0]))
      else $error("pointer address not on ports");
   a_one_space: assert property (@(posedge clk) disable iff (!reset_n)
      $onehot0(space_sel))
      else $error("more than one space selected");

endmodule : msd_decoder

// >>> test/msd_ext_mem.sv
// behavioural external data memory at the multiplexed port
`timescale 1ns/100ps
module msd_ext_mem (
   input  wire logic       clk,
   input  wire logic [7:0] addr_data_port_out,
   input  wire logic       addr_data_port_oe,
   input  wire logic [7:0] high_addr_port,
   input  wire logic       addr_latch,
   input  wire logic       wr_strobe_n,
   input  wire logic       rd_strobe_n,
   output logic [7:0]      addr_data_port_in
);
   logic [7:0]  mem [0:65535];
   logic [15:0] addr;

   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'(i) ^ 8'h5A;
      end
   end

   // address caught from both ports at the latch strobe
   always @(posedge clk) begin
      if (addr_latch) begin
         addr <= {high_addr_port, addr_data_port_out};
      end
      if (!wr_strobe_n) begin
         mem[addr] <= addr_data_port_out;
      end
   end

   // released port floats to the pull-up level
   assign addr_data_port_in =
      (!rd_strobe_n && !addr_data_port_oe) ? mem[addr] : 8'hFF;
endmodule : msd_ext_mem

// >>> test/memory_space_decoder_test.sv
// self-checking bench for the memory space decoder
`timescale 1ns/100ps
module memory_space_decoder_test;
   logic               clk        = 1'b0;
   logic               reset_n    = 1'b0;
   logic               pin        = 1'b1;
   logic               fetch_req  = 1'b0;
   logic [15:0]        fetch_addr = 16'h0000;
   logic               data_req   = 1'b0;
   msd_pkg::msd_kind_e data_kind  = msd_pkg::MSD_KIND_DIRECT;
   logic [15:0]        data_addr  = 16'h0000;
   logic               data_write = 1'b0;
   logic [7:0]         data_wdata = 8'h00;
   logic               bypass     = 1'b0;
   logic [7:0]         port2_val  = 8'hC3;
   wire logic [7:0]    port_in;
   logic               fi, fe, busy, done, poe, ale, wr_n, rd_n;
   logic [4:0]         sel;
   logic [7:0]         taddr, rdata, pout, hport;
   int                 n_fail     = 0;
   int                 cmp_count  = 0;

   always #50 clk = ~clk;

   msd_decoder #(.STROBE_CYCLES(3)) i_msd_decoder (
      .clk(clk), .reset_n(reset_n), .ext_fetch_select_pin(pin),
      .fetch_req(fetch_req), .fetch_addr(fetch_addr),
      .data_req(data_req), .data_kind(data_kind), .data_addr(data_addr),
      .data_write(data_write), .data_wdata(data_wdata),
      .aux_ram_bypass(bypass), .port2_out_reg(port2_val),
      .addr_data_port_in(port_in), .fetch_int_sel(fi),
      .fetch_ext_sel(fe), .space_sel(sel), .target_addr(taddr),
      .ext_busy(busy), .ext_done(done), .ext_rdata(rdata),
      .addr_data_port_out(pout), .addr_data_port_oe(poe),
      .high_addr_port(hport), .addr_latch(ale),
      .wr_strobe_n(wr_n), .rd_strobe_n(rd_n));

   msd_ext_mem i_msd_ext_mem (
      .clk(clk), .addr_data_port_out(pout), .addr_data_port_oe(poe),
      .high_addr_port(hport), .addr_latch(ale), .wr_strobe_n(wr_n),
      .rd_strobe_n(rd_n), .addr_data_port_in(port_in));

   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude

   // strap valid through reset, flipped afterwards
   task automatic do_reset(input logic level);
      @(negedge clk);
      reset_n = 1'b0;
      pin = level;
      repeat (12) @(negedge clk);
      reset_n = 1'b1;
      @(negedge clk);
      pin = ~level;
   endtask : do_reset

   task automatic fetch(input logic [15:0] a, input logic ext);
      @(negedge clk);
      fetch_req = 1'b1;
      fetch_addr = a;
      @(negedge clk);
      fetch_req = 1'b0;
      chk("fetch select", {14'h0, ~ext, ext}, {14'h0, fi, fe});
   endtask : fetch

   task automatic issue(input msd_pkg::msd_kind_e k, input logic [15:0] a,
                        input logic wr, input logic [7:0] wd);
      @(negedge clk);
      data_req = 1'b1;
      data_kind = k;
      data_addr = a;
      data_write = wr;
      data_wdata = wd;
      @(negedge clk);
      data_req = 1'b0;
   endtask : issue

   // internal or aux access: one space, bus left quiet
   task automatic int_access(input msd_pkg::msd_kind_e k,
                             input logic [15:0] a, input int idx);
      issue(k, a, 1'b0, 8'h00);
      chk("space select", 16'(5'h01 << idx), {11'h0, sel});
      chk("target address", {8'h00, a[7:0]}, {8'h00, taddr});
      chk("bus quiet", 16'h0003, {12'h0, ale, poe, wr_n, rd_n});
   endtask : int_access

   task automatic ext_access(input msd_pkg::msd_kind_e k,
                             input logic [15:0] a, input logic wr,
                             input logic [7:0] wd, input logic [7:0] hi,
                             input logic [7:0] rd_exp);
      int n;
      n = 0;
      issue(k, a, wr, wd);
      chk("space select", 16'(5'h01 << msd_pkg::SEL_EXT), {11'h0, sel});
      chk("address phase", {5'h0, 3'b111, a[7:0]},
          {5'h0, busy, ale, poe, pout});
      chk("high address", {8'h00, hi}, {8'h00, hport});
      @(negedge clk);
      chk("strobes", {14'h0, ~wr, wr}, {14'h0, wr_n, rd_n});
      if (wr) begin
         chk("write data", {8'h00, wd}, {8'h00, pout});
      end
      while (done !== 1'b1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      chk("strobe length", 16'd3, 16'(n));
      if (!wr) begin
         chk("read data", {8'h00, rd_exp}, {8'h00, rdata});
      end
      @(negedge clk);
      chk("bus released", 16'h0003, {12'h0, busy, poe, wr_n, rd_n});
   endtask : ext_access

   initial begin
      #(5000 * 100);
      n_fail++;
      $display("mismatch watchdog expected finish seen hang");
      conclude();
   end

   initial begin
      do_reset(1'b1);
      fetch(16'h3FFF, 1'b0); // top of internal
      fetch(16'h4000, 1'b1); // first external
      fetch(16'h0000, 1'b0); // pin ignored after reset
      do_reset(1'b0);
      fetch(16'h0000, 1'b1); // all external
      fetch(16'h3FFF, 1'b1); // pin ignored after reset
      do_reset(1'b1);
      int_access(msd_pkg::MSD_KIND_DIRECT, 16'h0000, 0); // direct low
      int_access(msd_pkg::MSD_KIND_DIRECT, 16'h007F, 0); // direct edge
      int_access(msd_pkg::MSD_KIND_INDIRECT, 16'h007F, 0); // indirect
      int_access(msd_pkg::MSD_KIND_DIRECT, 16'h0080, 2); // special regs
      int_access(msd_pkg::MSD_KIND_DIRECT, 16'h00A0, 2); // port reg
      int_access(msd_pkg::MSD_KIND_INDIRECT, 16'h00A0, 1); // upper ram
      int_access(msd_pkg::MSD_KIND_INDIRECT, 16'h00FF, 1); // upper top
      int_access(msd_pkg::MSD_KIND_STACK, 16'h0010, 0); // stack low
      int_access(msd_pkg::MSD_KIND_STACK, 16'h00FF, 1); // stack high
      int_access(msd_pkg::MSD_KIND_XMOV_IDX, 16'h00A0, 3); // aux
      int_access(msd_pkg::MSD_KIND_XMOV_PTR, 16'h00FF, 3); // aux
      int_access(msd_pkg::MSD_KIND_XMOV_PTR, 16'h0000, 3); // aux base
      ext_access(msd_pkg::MSD_KIND_XMOV_PTR, 16'h0100, 1'b1, 8'hA5,
                 8'h01, 8'h00); // store above aux
      ext_access(msd_pkg::MSD_KIND_XMOV_PTR, 16'h0100, 1'b0, 8'h00,
                 8'h01, 8'hA5); // load back
      bypass = 1'b1;
      ext_access(msd_pkg::MSD_KIND_XMOV_IDX, 16'h0055, 1'b1, 8'h77,
                 8'hC3, 8'h00); // paged store
      ext_access(msd_pkg::MSD_KIND_XMOV_PTR, 16'hC355, 1'b0, 8'h00,
                 8'hC3, 8'h77); // full pointer load
      ext_access(msd_pkg::MSD_KIND_XMOV_PTR, 16'h00FF, 1'b1, 8'h3C,
                 8'h00, 8'h00); // low page external
      ext_access(msd_pkg::MSD_KIND_XMOV_PTR, 16'h00FF, 1'b0, 8'h00,
                 8'h00, 8'h3C); // load back
      conclude();
   end
endmodule : memory_space_decoder_test
